// ===== hw/bpx_node.sv
// backplane node: transfer field coding, address decode and response lines
// How it works
// R1 - high parity covers tag, id and mask; low parity covers the data word
// R2 - each parity bit makes its field plus itself hold an even count of ones
// R3 - when nothing is sent every driven information line stays zero
// R4 - tags: read data 000, command 011, write data 101, summary read 110
// R5 - returned data mask: 0000 normal, 0001 corrected, 0010 substitute
// R6 - returned data carries the id of the node receiving it
// R7 - command carries own id; word splits into function and address
// R8 - command id is data destination on reads, data source on writes
// R9 - address bit 27 clear is memory, set is device register space
// R10 - byte address drops two low bits, which shift the byte mask
// R11 - node claims a 2048-longword register window placed by its line number
// R12 - write data, own id, follows directly after the command cycle
// R13 - summary read carries level mask in bits 7 to 4 with own id
// R14 - summary read drives the mask field as zero
// R15 - matching interrupt requester answers with its own identity
// R16 - node id equals its transfer request line number
// R17 - masked commands select bytes of the data word by mask bits
// R18 - mask bit n selects data bits 8n+7 down to 8n
// R19 - response group is a 2-bit confirm code plus one fault line
// R20 - malfunction raises fault with the same timing as the confirm code
// R21 - fault is latched, freezing the 16-entry history, until cleared
// R22 - confirm and fault come two cycles after the transfer
// R23 - confirm 00 none, 01 ack, 10 busy, 11 error; busy/error else none
`timescale 1ns/1ps
`include "bpx_params.svh"
module bpx_node
  import bpx_pkg::*;
#(
  parameter bit          MEM_EN = 1'b0,
  parameter logic [26:0] MEM_LO = 27'h0000000,
  parameter logic [26:0] MEM_HI = 27'h0000000
) (
  input  wire            clk,
  input  wire            reset_n,
  input  wire [4:0]      node_tr,
  input  wire bpx_info_t bus_in,
  input  wire bpx_resp_t resp_in,
  input  wire            path_grant,
  output bpx_info_t      bus_out,
  output logic           bus_oe,
  output bpx_resp_t      resp_out,
  output logic           path_req,
  output logic           path_hold,
  input  wire            cmd_valid,
  input  wire [3:0]      cmd_func,
  input  wire [29:0]     cmd_baddr,
  input  wire [3:0]      cmd_mask,
  input  wire [31:0]     cmd_wdata,
  input  wire            cmd_isr,
  input  wire [3:0]      cmd_level,
  output logic           cmd_ready,
  output logic           done_valid,
  output logic [1:0]     done_cnf,
  output logic           rdat_valid,
  output logic [31:0]    rdat,
  output logic [3:0]     rdat_kind,
  output logic           acc_valid,
  output logic           acc_write,
  output logic           acc_reg,
  output logic [26:0]    acc_addr,
  output logic [3:0]     acc_mask,
  output logic [31:0]    acc_wdata,
  input  wire            rd_valid,
  input  wire [31:0]     rd_data,
  input  wire [3:0]      rd_kind,
  input  wire            irq_pend,
  input  wire [3:0]      irq_level,
  input  wire            fault_clear,
  output logic           fault_latched,
  input  wire [3:0]      silo_idx,
  output bpx_info_t      silo_data
);
  // identity strap, caught once after reset release
  logic [4:0]  node_id_r;
  logic        id_cap_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      node_id_r <= 5'h00;
      id_cap_r  <= 1'b0;
    end else if (!id_cap_r) begin
      node_id_r <= node_tr; // R16
      id_cap_r  <= 1'b1;
    end
  end

  // receive stage: every transfer is latched and checked
  bpx_info_t   rx_r;
  logic        rx_ok_r;
  wire         in_ok;
  bpx_parity u_chk (
    .word (bus_in),
    .hpar (),
    .wpar (),
    .ok   (in_ok)
  );
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_r    <= '0;
      rx_ok_r <= 1'b1;
    end else begin
      rx_r    <= bus_in;
      rx_ok_r <= in_ok; // R2
    end
  end

  bpx_cmd_st_t st_r;
  bpx_cmd_st_t st_nxt;
  logic        busy_r;
  logic        wd_exp_r;
  logic [4:0]  peer_id_r;
  logic        isr_pend_r;
  logic        rtn_pend_r;
  logic [2:0]  rtn_sh_r;
  wire         tx_rtn;
  wire         tx_isr;

  wire [3:0]   rx_fn    = rx_r.data[31:28];
  wire [27:0]  rx_addr  = rx_r.data[27:0];
  wire         rx_reg   = rx_addr[`BPX_SPACE_BIT]; // R9
  wire [15:0]  win_idx  = `BPX_WIN_BASE + {11'h000, node_id_r};
  wire         hit_reg  = rx_reg && rx_addr[`BPX_WIN_MSB:`BPX_WIN_LSB] == win_idx; // R11
  wire         hit_mem  = MEM_EN && !rx_reg && rx_addr[`BPX_WIN_MSB:0] >= MEM_LO
                          && rx_addr[`BPX_WIN_MSB:0] <= MEM_HI; // R9
  wire         is_ca    = rx_ok_r && rx_r.tag == `BPX_TAG_CA; // R4
  wire         claim    = is_ca && (hit_reg || hit_mem);
  wire         fn_ok    = fn_reads(rx_fn) || fn_writes(rx_fn);
  wire         ca_ack   = claim && fn_ok && !busy_r;
  wire         wd_ok    = wd_exp_r && rx_ok_r && rx_r.tag == `BPX_TAG_WD
                          && rx_r.id == peer_id_r; // R8
  wire         rd_me    = rx_ok_r && rx_r.tag == `BPX_TAG_RD && rx_r.id == node_id_r
                          && st_r == ST_DATA;
  wire         isr_me   = rx_ok_r && rx_r.tag == `BPX_TAG_ISR && irq_pend && !isr_pend_r
                          && |(rx_r.data[`BPX_LVL_MSB:`BPX_LVL_LSB] & irq_level); // R15
  wire         rsv_tag  = rx_ok_r && (rx_r.tag == `BPX_TAG_RSV1 || rx_r.tag == `BPX_TAG_RSV2
                          || rx_r.tag == `BPX_TAG_RSV4);
  wire [1:0]   cnf_nxt  = claim ? (!fn_ok ? `BPX_CNF_ERR : busy_r ? `BPX_CNF_BSY : `BPX_CNF_ACK)
                          : (wd_ok || rd_me || isr_me) ? `BPX_CNF_ACK : `BPX_CNF_NR; // R23
  // parity faults, reserved tags and a missing write data word all count
  wire         flt_nxt  = !rx_ok_r || rsv_tag || (wd_exp_r && !wd_ok); // R20
  // only an ack counts for a returned word; busy or error means none
  wire         rtn_ack  = rtn_sh_r[2] && resp_in.cnf == `BPX_CNF_ACK; // R23
  wire         rtn_go   = rtn_pend_r && !(|rtn_sh_r);

  // responder side
  bpx_resp_t   resp_r;
  logic        acc_valid_r;
  logic        acc_write_r;
  logic        acc_reg_r;
  logic [26:0] acc_addr_r;
  logic [3:0]  acc_mask_r;
  logic [31:0] acc_wdata_r;
  bpx_info_t   rtn_word_r;
  bpx_info_t   isr_word_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_r      <= '0;
      wd_exp_r    <= 1'b0;
      peer_id_r   <= 5'h00;
      busy_r      <= 1'b0;
      acc_valid_r <= 1'b0;
      acc_write_r <= 1'b0;
      acc_reg_r   <= 1'b0;
      acc_addr_r  <= 27'h0000000;
      acc_mask_r  <= `BPX_MASK_NONE;
      acc_wdata_r <= 32'h0;
      rtn_pend_r  <= 1'b0;
      rtn_word_r  <= '0;
      rtn_sh_r    <= 3'h0;
      isr_pend_r  <= 1'b0;
      isr_word_r  <= '0;
    end else begin
      resp_r.cnf   <= cnf_nxt; // R22
      resp_r.fault <= flt_nxt; // R20
      wd_exp_r     <= ca_ack && fn_writes(rx_fn);
      acc_valid_r  <= (ca_ack && fn_reads(rx_fn)) || wd_ok;
      acc_write_r  <= wd_ok;
      if (ca_ack) begin
        peer_id_r  <= rx_r.id; // R8
        acc_reg_r  <= rx_reg;
        acc_addr_r <= rx_addr[`BPX_WIN_MSB:0];
        acc_mask_r <= rx_fn == `BPX_FN_XRD ? `BPX_MASK_ALL : rx_r.mask; // R17
      end
      if (wd_ok) begin
        acc_wdata_r <= lane_keep(rx_r.data, acc_mask_r); // R18
      end
      busy_r <= ca_ack || (busy_r && !wd_exp_r && !rtn_ack && !(acc_write_r && acc_valid_r));
      if (rd_valid && busy_r && !rtn_pend_r) begin
        rtn_pend_r      <= 1'b1;
        rtn_word_r.tag  <= `BPX_TAG_RD; // R4
        rtn_word_r.id   <= peer_id_r; // R6
        rtn_word_r.mask <= rd_kind; // R5
        rtn_word_r.data <= lane_keep(rd_data, acc_mask_r); // R18
      end else if (rtn_ack) begin
        rtn_pend_r <= 1'b0;
      end
      rtn_sh_r <= {rtn_sh_r[1:0], tx_rtn};
      if (isr_me) begin
        isr_pend_r      <= 1'b1;
        isr_word_r.tag  <= `BPX_TAG_RD;
        isr_word_r.id   <= rx_r.id;
        isr_word_r.mask <= `BPX_MASK_NONE;
        isr_word_r.data <= {27'h0000000, node_id_r}; // R15
      end else if (tx_isr) begin
        isr_pend_r <= 1'b0;
      end
    end
  end

  // commander side and transmit path
  logic        cmd_wr_r;
  logic        cmd_isr_r;
  logic [3:0]  cmd_func_r;
  logic [29:0] cmd_baddr_r;
  logic [3:0]  cmd_mask_r;
  logic [31:0] cmd_wdata_r;
  logic [3:0]  cmd_level_r;
  logic [1:0]  cnt_r;
  logic        cmd_ready_r;
  logic        path_req_r;
  wire         tx_free  = st_r != ST_CA && st_r != ST_WD;
  wire         want     = rtn_go || isr_pend_r || st_r == ST_ARB;
  wire         use_g    = path_grant && path_req_r && tx_free;
  assign tx_rtn = use_g && rtn_go;
  assign tx_isr = use_g && !rtn_go && isr_pend_r;
  wire         tx_ca    = use_g && !rtn_go && !isr_pend_r && st_r == ST_ARB;
  wire         tx_wd    = st_r == ST_CA && cmd_wr_r; // R12
  wire [3:0]   lanes    = lane_shift(cmd_mask_r, cmd_baddr_r[1:0]); // R10
  bpx_info_t   ca_w;
  bpx_info_t   wd_w;
  bpx_info_t   tx_raw;
  bpx_info_t   tx_nxt;
  wire         g_h;
  wire         g_w;
  assign ca_w.hpar = 1'b0;
  assign ca_w.wpar = 1'b0;
  assign ca_w.tag  = cmd_isr_r ? `BPX_TAG_ISR : `BPX_TAG_CA; // R4
  assign ca_w.id   = node_id_r; // R7
  assign ca_w.mask = cmd_isr_r ? `BPX_MASK_NONE : lanes; // R14
  assign ca_w.data = cmd_isr_r ? {24'h000000, cmd_level_r, 4'h0} // R13
                     : {cmd_func_r, cmd_baddr_r[29:2]}; // R7
  assign wd_w.hpar = 1'b0;
  assign wd_w.wpar = 1'b0;
  assign wd_w.tag  = `BPX_TAG_WD;
  assign wd_w.id   = node_id_r; // R12
  assign wd_w.mask = lanes;
  assign wd_w.data = cmd_wdata_r;
  // anything not sent is forced to zero so idle lines keep even parity
  assign tx_raw = tx_rtn ? rtn_word_r : tx_isr ? isr_word_r : tx_ca ? ca_w
                  : tx_wd ? wd_w : '0; // R3
  bpx_parity u_gen (
    .word (tx_raw),
    .hpar (g_h),
    .wpar (g_w),
    .ok   ()
  );
  assign tx_nxt = {g_h, g_w, tx_raw.tag, tx_raw.id, tx_raw.mask, tx_raw.data}; // R1

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (cmd_valid && cmd_ready_r) st_nxt = ST_ARB;
      ST_ARB:  if (tx_ca) st_nxt = ST_CA;
      ST_CA:   st_nxt = cmd_wr_r ? ST_WD : ST_CNF;
      ST_WD:   st_nxt = ST_CNF;
      ST_CNF:  if (cnt_r == 2'h0) st_nxt = (resp_in.cnf == `BPX_CNF_ACK && !cmd_wr_r) ? ST_DATA : ST_IDLE;
      ST_DATA: if (rd_me) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  bpx_info_t   bus_r;
  logic        oe_r;
  logic        hold_r;
  logic        done_r;
  logic [1:0]  done_cnf_r;
  logic        rdat_valid_r;
  logic [31:0] rdat_r;
  logic [3:0]  rdat_kind_r;
  wire         cnf_due = st_r == ST_CNF && cnt_r == 2'h0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= ST_IDLE;
      cmd_ready_r  <= 1'b0;
      cmd_wr_r     <= 1'b0;
      cmd_isr_r    <= 1'b0;
      cmd_func_r   <= 4'h0;
      cmd_baddr_r  <= 30'h00000000;
      cmd_mask_r   <= `BPX_MASK_NONE;
      cmd_wdata_r  <= 32'h0;
      cmd_level_r  <= 4'h0;
      cnt_r        <= 2'h0;
      bus_r        <= '0;
      oe_r         <= 1'b0;
      hold_r       <= 1'b0;
      path_req_r   <= 1'b0;
      done_r       <= 1'b0;
      done_cnf_r   <= `BPX_CNF_NR;
      rdat_valid_r <= 1'b0;
      rdat_r       <= 32'h0;
      rdat_kind_r  <= `BPX_RDK_NORM;
    end else begin
      st_r        <= st_nxt;
      cmd_ready_r <= st_nxt == ST_IDLE;
      if (st_r == ST_IDLE && cmd_valid && cmd_ready_r) begin
        cmd_wr_r    <= !cmd_isr && fn_writes(cmd_func);
        cmd_isr_r   <= cmd_isr;
        cmd_func_r  <= cmd_func;
        cmd_baddr_r <= cmd_baddr;
        cmd_mask_r  <= cmd_mask;
        cmd_wdata_r <= cmd_wdata;
        cmd_level_r <= cmd_level;
      end
      if (st_r == ST_CA) begin
        cnt_r <= `BPX_CNF_DELAY - 2'h1; // R22
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
      bus_r        <= tx_nxt;
      oe_r         <= tx_rtn || tx_isr || tx_ca || tx_wd;
      // hold keeps arbitration for the data cycle of a write
      hold_r       <= tx_ca && cmd_wr_r;
      path_req_r   <= want && !use_g;
      done_r       <= (cnf_due && st_nxt == ST_IDLE) || rd_me;
      done_cnf_r   <= rd_me ? `BPX_CNF_ACK : resp_in.cnf;
      rdat_valid_r <= rd_me;
      if (rd_me) begin
        rdat_r      <= rx_r.data;
        rdat_kind_r <= rx_r.mask; // R5
      end
    end
  end

  // fault latch: a new fault wins over a clear in the same cycle
  logic        flt_lat_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flt_lat_r <= 1'b0;
    end else begin
      flt_lat_r <= resp_in.fault || resp_r.fault || (flt_lat_r && !fault_clear); // R21
    end
  end

  bpx_silo #(
    .DEPTH (`BPX_SILO_DEPTH)
  ) u_silo (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (rx_r != '0),
    .freeze  (flt_lat_r), // R21
    .entry   (rx_r),
    .rd_idx  (silo_idx),
    .rd_data (silo_data)
  );

  assign bus_out       = bus_r;
  assign bus_oe        = oe_r;
  assign resp_out      = resp_r; // R19
  assign path_req      = path_req_r;
  assign path_hold     = hold_r;
  assign cmd_ready     = cmd_ready_r;
  assign done_valid    = done_r;
  assign done_cnf      = done_cnf_r;
  assign rdat_valid    = rdat_valid_r;
  assign rdat          = rdat_r;
  assign rdat_kind     = rdat_kind_r;
  assign acc_valid     = acc_valid_r;
  assign acc_write     = acc_write_r;
  assign acc_reg       = acc_reg_r;
  assign acc_addr      = acc_addr_r;
  assign acc_mask      = acc_mask_r;
  assign acc_wdata     = acc_wdata_r;
  assign fault_latched = flt_lat_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence ca_wr_s;
    bus_oe && bus_out.tag == `BPX_TAG_CA && cmd_wr_r;
  endsequence
  sequence wd_own_s;
    bus_oe && bus_out.tag == `BPX_TAG_WD && bus_out.id == node_id_r;
  endsequence
  idle_zero_a : assert property (!bus_oe |-> bus_out == '0) // R3
    else $error("idle lines not zero");
  tx_parity_a : assert property (bus_oe |-> !(^{bus_out.hpar, bus_out.tag, bus_out.id, bus_out.mask})
                                 && !(^{bus_out.wpar, bus_out.data})) // R1
    else $error("sent parity odd");
  write_follow_a : assert property (ca_wr_s |=> wd_own_s) // R12
    else $error("write data not next cycle");
  isr_fields_a : assert property (bus_oe && bus_out.tag == `BPX_TAG_ISR
                                  |-> bus_out.mask == 4'h0 && bus_out.id == node_id_r) // R14
    else $error("summary read fields wrong");
  ca_addr_a : assert property (bus_oe && bus_out.tag == `BPX_TAG_CA
                               |-> bus_out.data[27:0] == cmd_baddr_r[29:2]) // R10
    else $error("longword address wrong");
  rtn_kind_a : assert property (bus_oe && bus_out.tag == `BPX_TAG_RD && !isr_pend_r
                                |-> bus_out.mask <= 4'h2) // R5
    else $error("read data kind invalid");
  parity_fault_a : assert property (!in_ok |-> ##2 resp_out.fault) // R20
    else $error("parity fault not reported");
  claim_cnf_a : assert property (bus_in.tag == `BPX_TAG_CA && in_ok && bus_in.data[27]
                                 && bus_in.data[26:11] == win_idx && id_cap_r
                                 |-> ##2 resp_out.cnf != 2'h0) // R22
    else $error("claimed command not confirmed");
  fault_hold_a : assert property (fault_latched && !fault_clear |=> fault_latched) // R21
    else $error("fault latch dropped");
endmodule : bpx_node

// ===== hw/bpx_params.svh
// constants of the backplane transfer field logic
`ifndef BPX_PARAMS_SVH
`define BPX_PARAMS_SVH
`define BPX_TAG_RD    3'h0
`define BPX_TAG_RSV1  3'h1
`define BPX_TAG_RSV2  3'h2
`define BPX_TAG_CA    3'h3
`define BPX_TAG_RSV4  3'h4
`define BPX_TAG_WD    3'h5
`define BPX_TAG_ISR   3'h6
`define BPX_TAG_DIAG  3'h7
`define BPX_RDK_NORM  4'h0
`define BPX_RDK_CORR  4'h1
`define BPX_RDK_SUBST 4'h2
`define BPX_MASK_NONE 4'h0
`define BPX_MASK_ALL  4'hf
`define BPX_CNF_NR    2'h0
`define BPX_CNF_ACK   2'h1
`define BPX_CNF_BSY   2'h2
`define BPX_CNF_ERR   2'h3
`define BPX_FN_RDM    4'h1
`define BPX_FN_WRM    4'h2
`define BPX_FN_IRDM   4'h4
`define BPX_FN_IWRM   4'h7
`define BPX_FN_XRD    4'h8
`define BPX_FN_XWRM   4'hb
`define BPX_SPACE_BIT 27
`define BPX_WIN_MSB   26
`define BPX_WIN_LSB   11
`define BPX_WIN_BASE  16'h0000
`define BPX_LVL_MSB   7
`define BPX_LVL_LSB   4
`define BPX_CNF_DELAY 2'h2
`define BPX_SILO_DEPTH 16
`endif

// ===== hw/bpx_parity.sv
// even parity generator and checker for one information transfer
`timescale 1ns/1ps
module bpx_parity
  import bpx_pkg::*;
(
  input  wire bpx_info_t word,
  output logic           hpar,
  output logic           wpar,
  output logic           ok
);
  assign hpar = ^{word.tag, word.id, word.mask};
  assign wpar = ^word.data;
  assign ok   = (hpar == word.hpar) && (wpar == word.wpar);
endmodule : bpx_parity

// ===== hw/bpx_pkg.sv
// types and helpers of the backplane transfer field logic
`include "bpx_params.svh"
package bpx_pkg;
  typedef struct packed {
    logic        hpar;
    logic        wpar;
    logic [2:0]  tag;
    logic [4:0]  id;
    logic [3:0]  mask;
    logic [31:0] data;
  } bpx_info_t;

  typedef struct packed {
    logic [1:0] cnf;
    logic       fault;
  } bpx_resp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB  = 3'h1,
    ST_CA   = 3'h2,
    ST_WD   = 3'h3,
    ST_CNF  = 3'h4,
    ST_DATA = 3'h5
  } bpx_cmd_st_t;

  function automatic logic fn_reads(input logic [3:0] f);
    return f == `BPX_FN_RDM || f == `BPX_FN_IRDM || f == `BPX_FN_XRD;
  endfunction : fn_reads

  function automatic logic fn_writes(input logic [3:0] f);
    return f == `BPX_FN_WRM || f == `BPX_FN_IWRM || f == `BPX_FN_XWRM;
  endfunction : fn_writes

  function automatic logic [3:0] lane_shift(input logic [3:0] m, input logic [1:0] off);
    logic [3:0] s;
    s = m << off;
    return s;
  endfunction : lane_shift

  function automatic logic [31:0] lane_keep(input logic [31:0] d, input logic [3:0] m);
    logic [31:0] k;
    k = 32'h0;
    for (int i = 0; i < 4; i++) begin
      k[8*i+:8] = m[i] ? d[8*i+:8] : 8'h00;
    end
    return k;
  endfunction : lane_keep
endpackage : bpx_pkg

// ===== hw/bpx_silo.sv
// history buffer of recent bus transfers, frozen on fault
`timescale 1ns/1ps
module bpx_silo
  import bpx_pkg::*;
#(
  parameter int DEPTH = `BPX_SILO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire            clk,
  input  wire            reset_n,
  input  wire            wr_en,
  input  wire            freeze,
  input  wire bpx_info_t entry,
  input  wire [AW-1:0]   rd_idx,
  output bpx_info_t      rd_data
);
  bpx_info_t         mem_r [DEPTH];
  logic [AW-1:0]     ptr_r;
  bpx_info_t         rd_r;
  wire               push = wr_en && !freeze;
  // index 0 is the newest entry
  wire [AW-1:0]      rd_pos = ptr_r - rd_idx - 1'b1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= '0;
      rd_r  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      rd_r <= mem_r[rd_pos];
      if (push) begin
        mem_r[ptr_r] <= entry; // R21
        ptr_r        <= ptr_r + 1'b1;
      end
    end
  end

  assign rd_data = rd_r;

  frozen_ptr_a : assert property (@(posedge clk) disable iff (!reset_n) freeze |=> $stable(ptr_r)) // R21
    else $error("silo moved while frozen");
endmodule : bpx_silo

// ===== sim/bpx_node_tb.sv
// self-checking bench of the backplane node
`timescale 1ns/1ps
module bpx_node_tb;
  import bpx_pkg::*;
  typedef struct packed {
    logic [2:0]  tag;
    logic [4:0]  id;
    logic [3:0]  mask;
    logic [31:0] data;
    logic        bad;
    logic [1:0]  cnf;
    logic        flt;
  } bpx_row_t;
  logic        clk = 0, reset_n = 0, send = 0, bad_par = 0, gwait = 0, fault_clear = 0;
  logic        cmd_valid = 0, cmd_isr = 0, rd_valid = 0, irq_pend = 0;
  logic [1:0]  cnf_reply = 2'h1;
  logic [3:0]  cmd_func = 0, cmd_mask = 0, cmd_level = 0, rd_kind = 0, irq_level = 0, silo_idx = 0;
  logic [29:0] cmd_baddr = 0;
  logic [31:0] cmd_wdata = 0, rd_data = 0, rdat, acc_wdata;
  bpx_info_t   tx = '0, bus_in, bus_out, silo_data, w;
  bpx_resp_t   resp_in, resp_out;
  logic        path_grant, bus_oe, path_req, path_hold, cmd_ready, done_valid, rdat_valid;
  logic        acc_valid, acc_write, acc_reg, fault_latched;
  logic [1:0]  done_cnf;
  logic [3:0]  rdat_kind, acc_mask;
  logic [26:0] acc_addr;
  logic [46:0] capq[$];
  bpx_row_t    r;
  int          n_mismatch = 0, n_tests = 0;
  logic [47:0] rows [9] = '{
    {3'h3, 5'h2, 4'hf, 32'h0800280c, 1'b0, 2'h3, 1'b0},
    {3'h3, 5'h2, 4'hf, 32'h9800280c, 1'b0, 2'h3, 1'b0},
    {3'h3, 5'h2, 4'hf, 32'h18003000, 1'b0, 2'h0, 1'b0},
    {3'h3, 5'h2, 4'hf, 32'h10000100, 1'b0, 2'h0, 1'b0},
    {3'h0, 5'h3, 4'h0, 32'h12345678, 1'b0, 2'h0, 1'b0},
    {3'h1, 5'h2, 4'h0, 32'h00000000, 1'b0, 2'h0, 1'b1},
    {3'h2, 5'h2, 4'h0, 32'h00000000, 1'b0, 2'h0, 1'b1},
    {3'h4, 5'h2, 4'h0, 32'h00000000, 1'b0, 2'h0, 1'b1},
    {3'h3, 5'h2, 4'hf, 32'h18003000, 1'b1, 2'h0, 1'b1}};

  always #25 clk = ~clk;
  always @(posedge clk) if (bus_oe === 1'b1) capq.push_back({path_hold, bus_out});

  bpx_node u_dut (.clk, .reset_n, .node_tr(5'h5), .bus_in, .resp_in, .path_grant, .bus_out, .bus_oe,
    .resp_out, .path_req, .path_hold, .cmd_valid, .cmd_func, .cmd_baddr, .cmd_mask, .cmd_wdata, .cmd_isr,
    .cmd_level, .cmd_ready, .done_valid, .done_cnf, .rdat_valid, .rdat, .rdat_kind, .acc_valid, .acc_write,
    .acc_reg, .acc_addr, .acc_mask, .acc_wdata, .rd_valid, .rd_data, .rd_kind, .irq_pend, .irq_level,
    .fault_clear, .fault_latched, .silo_idx, .silo_data);
  bpx_peer u_peer (.clk, .reset_n, .send, .tx, .bad_par, .gwait, .cnf_reply, .path_req, .bus_oe, .bus_in,
    .resp_in, .path_grant);

  function automatic bpx_info_t mk(logic [2:0] t, logic [4:0] i, logic [3:0] m, logic [31:0] d);
    return {^{t, i, m}, ^d, t, i, m, d};
  endfunction : mk
  task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic put(bpx_info_t v, logic b);
    @(posedge clk);
    send    <= 1'b1;
    tx      <= v;
    bad_par <= b;
  endtask : put
  // word of the last put is on the bus from the first edge; n edges later the check point
  task automatic idle(int n);
    @(posedge clk);
    send <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic cmd(logic [3:0] f, logic [29:0] a, logic [3:0] m, logic [31:0] d, logic isr, logic [3:0] l);
    repeat (2) @(posedge clk);
    {cmd_valid, cmd_func, cmd_baddr, cmd_mask, cmd_wdata, cmd_isr, cmd_level} <= {1'b1, f, a, m, d, isr, l};
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic wcap(int n);
    for (int i = 0; i < 60 && capq.size() < n; i++) @(negedge clk);
    chk("capture count", 1, capq.size() >= n);
  endtask : wcap
  task automatic wdone;
    for (int i = 0; i < 60 && done_valid !== 1'b1; i++) @(negedge clk);
    chk("done seen", 1, done_valid);
  endtask : wdone
  task automatic fclr;
    @(posedge clk);
    fault_clear <= 1'b1;
    @(posedge clk);
    fault_clear <= 1'b0;
    @(posedge clk);
    #1;
  endtask : fclr
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 chk("reset outputs", 0, {bus_oe, bus_out, cmd_ready, resp_out});
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("ready", 1, cmd_ready);
    $display("test reset finished");
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      put(mk(r.tag, r.id, r.mask, r.data), r.bad);
      idle(2);
      chk("resp", {r.cnf, r.flt}, resp_out);
    end
    chk("fault latch", 1, fault_latched);
    w = mk(3'h3, 5'h2, 4'hf, 32'h18004000);
    put(w, 1'b0);
    idle(4);
    n_tests++;
    if (silo_data === w) begin
      n_mismatch++;
      $display("[FAIL] silo frozen expected old entry seen %h", silo_data);
    end
    fclr();
    chk("fault cleared", 0, fault_latched);
    put(w, 1'b0);
    idle(4);
    chk("silo newest", w, silo_data);
    chk("idle lines", 0, bus_out);
    $display("test table finished");
    put(mk(3'h3, 5'h2, 4'hf, 32'h2800280c), 1'b0);
    idle(2);
    chk("lone write cnf", 2'h1, resp_out.cnf);
    @(posedge clk);
    #1 chk("lone write fault", 1, resp_out.fault);
    fclr();
    put(mk(3'h3, 5'h2, 4'h5, 32'h2800280c), 1'b0);
    put(mk(3'h5, 5'h2, 4'h5, 32'h11223344), 1'b0);
    idle(2);
    chk("local write", {2'h1, 1'b1, 1'b1, 1'b1, 27'h000280c, 4'h5, 32'h00220044},
        {resp_out.cnf, acc_valid, acc_write, acc_reg, acc_addr, acc_mask, acc_wdata});
    $display("test device write finished");
    put(mk(3'h3, 5'h2, 4'hf, 32'h1800280c), 1'b0);
    idle(2);
    chk("read claim", {2'h1, 1'b1, 1'b0}, {resp_out.cnf, acc_valid, acc_write});
    put(mk(3'h3, 5'h2, 4'hf, 32'h1800280c), 1'b0);
    idle(2);
    chk("busy", 2'h2, resp_out.cnf);
    capq.delete();
    cnf_reply <= 2'h2;
    @(posedge clk);
    {rd_valid, rd_data, rd_kind} <= {1'b1, 32'hcafe0001, 4'h1};
    @(posedge clk);
    rd_valid <= 1'b0;
    wcap(1);
    @(posedge clk);
    cnf_reply <= 2'h1;
    wcap(2);
    chk("return word", mk(3'h0, 5'h2, 4'h1, 32'hcafe0001), capq[0][45:0]);
    chk("resent word", mk(3'h0, 5'h2, 4'h1, 32'hcafe0001), capq[1][45:0]);
    $display("test device read finished");
    capq.delete();
    gwait <= 1'b1;
    cmd(4'h2, 30'h01234561, 4'h3, 32'h5a5a0ff0, 1'b0, 4'h0);
    repeat (5) @(posedge clk);
    gwait <= 1'b0;
    wdone();
    chk("write done", 2'h1, done_cnf);
    chk("command word", {1'b1, mk(3'h3, 5'h5, 4'h6, 32'h2048d158)}, capq[0]);
    w = capq[1][45:0];
    chk("write data", {3'h5, 5'h5, 32'h5a5a0ff0}, {w.tag, w.id, w.data});
    chk("write parity", mk(w.tag, w.id, w.mask, w.data), w);
    capq.delete();
    cnf_reply <= 2'h2;
    cmd(4'h1, 30'h00000040, 4'hf, 32'h0, 1'b0, 4'h0);
    wdone();
    chk("read refused", 2'h2, done_cnf);
    cnf_reply <= 2'h1;
    cmd(4'h1, 30'h00000040, 4'hf, 32'h0, 1'b0, 4'h0);
    wcap(2);
    repeat (3) @(posedge clk);
    put(mk(3'h0, 5'h5, 4'h2, 32'h0badf00d), 1'b0);
    idle(0);
    wdone();
    chk("read data", {1'b1, 32'h0badf00d, 4'h2}, {rdat_valid, rdat, rdat_kind});
    $display("test commander finished");
    capq.delete();
    {irq_pend, irq_level} <= {1'b1, 4'h8};
    put(mk(3'h6, 5'h1, 4'h0, 32'h00000080), 1'b0);
    idle(2);
    chk("summary ack", 2'h1, resp_out.cnf);
    wcap(1);
    chk("summary answer", mk(3'h0, 5'h1, 4'h0, 32'h00000005), capq[0][45:0]);
    irq_pend <= 1'b0;
    capq.delete();
    cmd(4'h0, 30'h0, 4'h0, 32'h0, 1'b1, 4'h8);
    wcap(1);
    chk("summary read", mk(3'h6, 5'h5, 4'h0, 32'h00000080), capq[0][45:0]);
    $display("test interrupt finished");
    conclude();
  end
endmodule : bpx_node_tb

// ===== sim/bpx_peer.sv
// far-side node model: sends words, grants the path and confirms what the node sends
`timescale 1ns/1ps
module bpx_peer
  import bpx_pkg::*;
(
  input  wire            clk,
  input  wire            reset_n,
  input  wire            send,
  input  wire bpx_info_t tx,
  input  wire            bad_par,
  input  wire            gwait,
  input  wire [1:0]      cnf_reply,
  input  wire            path_req,
  input  wire            bus_oe,
  output bpx_info_t      bus_in,
  output bpx_resp_t      resp_in,
  output logic           path_grant
);
  logic oe_d1_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_in     <= '0;
      resp_in    <= '0;
      path_grant <= 1'b0;
      oe_d1_r    <= 1'b0;
    end else begin
      // released lines rest at zero, which is already even parity
      bus_in     <= send ? {^{tx.tag, tx.id, tx.mask} ^ bad_par, ^tx.data, tx.tag, tx.id, tx.mask, tx.data} : '0;
      // one-cycle grant pulse, held off while this side talks or stalls
      path_grant <= path_req & ~path_grant & ~bus_oe & ~send & ~gwait;
      oe_d1_r    <= bus_oe;
      resp_in    <= oe_d1_r ? {cnf_reply, 1'b0} : '0;
    end
  end
endmodule : bpx_peer
